// >>> dv/ssp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    input wire logic sck,
    input wire logic cpol,
    input wire logic cpha0,
    input wire logic sel,
    input wire logic load,
    input wire logic sdo,
    input wire logic [7:0] tx,
    output logic sdi,
    output logic [7:0] rx
);
    logic [7:0] sr = 8'h00;
    logic b = 1'b0;
    wire s = sck ^ cpol;
    assign sdi = sel ? b : ~b;
    always @(posedge load) begin
        sr = tx;
        b = cpha0 ? tx[7] : ~tx[7];
        rx = 8'h00;
    end
    always @(posedge s) begin
        if (cpha0) begin
            rx = {rx[6:0], sdo};
        end else begin
            b = sr[7];
            sr = sr << 1;
        end
    end
    always @(negedge s) begin
        if (!cpha0) begin
            rx = {rx[6:0], sdo};
        end else begin
            sr = sr << 1;
            b = sr[7];
        end
    end
endmodule
`default_nettype wire

// >>> dv/ssp_spi_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port_chk (
    input wire clk_sys,
    input wire rst,
    input wire master_en,
    input wire slave_select_en,
    input wire open_drain_select,
    input wire buf_wr,
    input wire buf_rd,
    input wire write_collision_flag_clear,
    input wire irq_clear,
    input wire buffer_full_flag_q,
    input wire port_irq_flag_q,
    input wire write_collision_flag_q,
    input wire busy_q,
    input wire ss_n_i,
    input wire sck_o_q,
    input wire sck_oe_q,
    input wire sdo_o_q,
    input wire sdo_oe_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Sync lag on select, so deselect must last a while
    sequence s_desel;
        (!master_en && slave_select_en && ss_n_i)[*6];
    endsequence
    sequence s_start;
        buf_wr && master_en && !busy_q && !$past(buf_wr);
    endsequence
    // busy_q shows the state that judged the write
    property p_write_collision_flag;
        buf_wr && !write_collision_flag_clear && !write_collision_flag_q |=> write_collision_flag_q == busy_q;
    endproperty
    property p_sticky;
        write_collision_flag_q && !write_collision_flag_clear |=> write_collision_flag_q;
    endproperty
    property p_rd;
        buf_rd && !busy_q && master_en |=> !buffer_full_flag_q;
    endproperty
    property p_irq;
        $rose(buffer_full_flag_q) |-> port_irq_flag_q || $past(irq_clear);
    endproperty
    property p_od;
        open_drain_select && $past(open_drain_select)
            |-> !(sdo_oe_q && sdo_o_q) && !(sck_oe_q && sck_o_q);
    endproperty
    property p_slv;
        !master_en && !$past(master_en) |-> !sck_oe_q;
    endproperty
    property p_desel;
        s_desel |-> !sdo_oe_q;
    endproperty
    property p_start;
        s_start |-> ##[1:3] busy_q;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag wrong");
    a_sticky: assert property (p_sticky) else $error("collision flag lost");
    a_rd: assert property (p_rd) else $error("full flag kept");
    a_irq: assert property (p_irq) else $error("irq missing");
    a_od: assert property (p_od) else $error("pin driven high");
    a_slv: assert property (p_slv) else $error("slave drives clock");
    a_desel: assert property (p_desel) else $error("data driven deselected");
    a_start: assert property (p_start) else $error("no start");
endmodule
bind ssp_spi_port ssp_spi_port_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .master_en(master_en), .slave_select_en(slave_select_en),
    .open_drain_select(open_drain_select), .buf_wr(buf_wr), .buf_rd(buf_rd),
    .write_collision_flag_clear(write_collision_flag_clear), .irq_clear(irq_clear), .buffer_full_flag_q(buffer_full_flag_q),
    .port_irq_flag_q(port_irq_flag_q), .write_collision_flag_q(write_collision_flag_q),
    .busy_q(busy_q), .ss_n_i(ss_n_i), .sck_o_q(sck_o_q), .sck_oe_q(sck_oe_q),
    .sdo_o_q(sdo_o_q), .sdo_oe_q(sdo_oe_q)
);
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, master_en = 1'b1, cpol = 1'b0, cpha0 = 1'b1;
    logic ss_en = 1'b0, od = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0, write_collision_flag_clear = 1'b0;
    logic irq_clear = 1'b0, tb_sck = 1'b0, tb_sdi = 1'b0, ss_n = 1'b1, load = 1'b0;
    logic [1:0] rate = 2'h0;
    logic late = 1'b0;
    logic [7:0] wdata = 8'h00, ptx = 8'h00, wd = 8'h00, acc = 8'h00;
    wire [7:0] xbuf, prx;
    wire full, irq, write_collision_flag, busy, ovr, sck_o, sck_oe, sdo_o, sdo_oe, psdi;
    int mismatches = 0, samples_checked = 0;
    // Pull-ups on both lines, so open drain reads back high
    wire sdo_w = sdo_oe ? sdo_o : 1'b1;
    wire sck_w = sck_oe ? sck_o : (master_en ? 1'b1 : tb_sck);
    wire sdi_w = master_en ? psdi : tb_sdi;

    always #50 clk_sys = ~clk_sys;

    ssp_spi_port DUT (
        .clk_sys(clk_sys), .rst(rst), .master_en(master_en), .clk_idle_high(cpol),
        .sample_late(late), .out_on_idle_edge(cpha0), .clk_rate_sel(rate),
        .slave_select_en(ss_en), .open_drain_select(od), .buf_wr(buf_wr),
        .buf_wr_data(wdata), .buf_rd(buf_rd), .write_collision_flag_clear(write_collision_flag_clear), .irq_clear(irq_clear),
        .xfer_buffer_q(xbuf), .buffer_full_flag_q(full), .port_irq_flag_q(irq),
        .write_collision_flag_q(write_collision_flag), .busy_q(busy), .rx_overrun_q(ovr), .sck_i(sck_w),
        .sck_o_q(sck_o), .sck_oe_q(sck_oe), .sdi_i(sdi_w), .sdo_o_q(sdo_o),
        .sdo_oe_q(sdo_oe), .ss_n_i(ss_n)
    );
    ssp_peer u_peer (
        .sck(sck_w), .cpol(cpol), .cpha0(cpha0), .sel(master_en), .load(load),
        .sdo(sdo_w), .tx(ptx), .sdi(psdi), .rx(prx)
    );

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        step;
        buf_wr = 1'b1;
        wdata = d;
        step;
        buf_wr = 1'b0;
    endtask
    // 0 reads the buffer, 1 clears collision, 2 clears irq
    task automatic pulse(input int k);
        step;
        {buf_rd, write_collision_flag_clear, irq_clear} = 3'b100 >> k;
        step;
        {buf_rd, write_collision_flag_clear, irq_clear} = 3'h0;
    endtask
    task automatic wait_full;
        int n;
        n = 0;
        while (full !== 1'b1 && n < 6000) begin
            step;
            n++;
        end
        if (full !== 1'b1) begin
            mismatches++;
        end
    endtask
    task automatic sbit(input logic bi);
        tb_sdi = bi;
        repeat (4) step;
        tb_sck = 1'b1;
        repeat (4) step;
        // Slave output lags its clock pin, so take it at the closing edge
        acc = {acc[6:0], sdo_w};
        tb_sck = 1'b0;
    endtask
    task automatic close_out;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        close_out;
    end

    initial begin
        repeat (3) step;
        rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            step;
            {cpol, cpha0} = m[1:0];
            rate = m[1:0];
            late = m[1];
            od = (m == 2);
            ptx = 8'hc3 >> m;
            wd = 8'h80 | m[7:0];
            step;
            load = 1'b1;
            step;
            load = 1'b0;
            wr(wd);
            wr(8'hff);
            chk(write_collision_flag, 8'h01);
            wait_full;
            chk(xbuf, ptx);
            chk(irq, 8'h01);
            chk(prx, wd);
            chk(write_collision_flag, 8'h01);
            pulse(0);
            chk(full, 8'h00);
            pulse(1);
            pulse(2);
            chk({write_collision_flag, irq}, 8'h00);
        end
        step;
        master_en = 1'b0;
        ss_en = 1'b1;
        {cpol, cpha0} = 2'b01;
        wr(8'h6b);
        for (int i = 0; i < 3; i++) sbit(1'b1);
        chk({ovr, busy, sdo_oe, sck_oe}, 8'h00);
        ss_n = 1'b0;
        repeat (4) step;
        acc = 8'h00;
        for (int j = 0; j < 2; j++) begin
            for (int i = 7; i >= 0; i--) sbit(wd[i] ^ j[0]);
            if (j == 0) chk(acc, 8'h6b);
        end
        ss_n = 1'b1;
        wait_full;
        chk(xbuf, wd);
        pulse(0);
        repeat (4) step;
        chk(xbuf, ~wd);
        close_out;
    end
endmodule
`default_nettype wire

// >>> pkg/ssp_defs.vh
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// Byte geometry
`define SSP_BYTE_W 8
`define SSP_LAST_BIT 3'd7

// Receive queue depth and pointer width
`define SSP_FIFO_DEPTH 4
`define SSP_FIFO_AW 2

// Master half-period lengths in clk_sys cycles, per rate select
// Fastest rate still covers the input synchroniser lag on returning data
`define SSP_HALF_RATE0 8'd6
`define SSP_HALF_RATE1 8'd8
`define SSP_HALF_RATE2 8'd32
`define SSP_HALF_RATE3 8'd128

// Master half-period tick indices
`define SSP_TICK_LAST_TOGGLE 5'd16
`define SSP_TICK_LATE_END 5'd17
`define SSP_TICK_FIRST_LATE 5'd3

// Rate select codes
`define SSP_RATE_SEL0 2'h0
`define SSP_RATE_SEL1 2'h1
`define SSP_RATE_SEL2 2'h2

`endif

// >>> rtl/ssp_spi_port.v
// Summary of operation
// - Full-duplex eight-bit byte per transfer
// - All four polarity and phase modes
// - Master drives clock, slave receives it
// - Optional slave select addresses slave port
// - Config inputs pick role, timing, rate
// - One shift register, MSb first
// - Byte done: buffer, full flag, irq
// - Received bytes queued four deep before the buffer
// - Write during transfer dropped, collision set
// - Collision flag sticky until software clears
// - Buffer read clears full flag unless a queued byte reloads the buffer
// - Shift register reached only via buffer
// - Open-drain select for data, clock pins
// - Rate master-only, select mode slave-only
`include "ssp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_sys,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

module ssp_spi_port (
    input wire clk_sys,
    input wire rst,
    input wire master_en,
    input wire clk_idle_high,
    input wire sample_late,
    input wire out_on_idle_edge,
    input wire [1:0] clk_rate_sel,
    input wire slave_select_en,
    input wire open_drain_select,
    input wire buf_wr,
    input wire [7:0] buf_wr_data,
    input wire buf_rd,
    input wire write_collision_flag_clear,
    input wire irq_clear,
    output reg [7:0] xfer_buffer_q,
    output reg buffer_full_flag_q,
    output reg port_irq_flag_q,
    output reg write_collision_flag_q,
    output reg busy_q,
    output reg rx_overrun_q,
    input wire sck_i,
    output reg sck_o_q,
    output reg sck_oe_q,
    input wire sdi_i,
    output reg sdo_o_q,
    output reg sdo_oe_q,
    input wire ss_n_i
);
    localparam ST_IDLE = 3'b001;
    localparam ST_PEND = 3'b010;
    localparam ST_RUN = 3'b100;

    // Pin synchronisers: value accepted once stages two and three agree
    reg [2:0] sck_sync_q;
    reg [2:0] sdi_sync_q;
    reg [2:0] ss_sync_q;
    reg sck_s_q;
    reg sdi_s_q;
    reg ss_n_s_q;
    reg sck_prev_q;

    reg [2:0] state_q;
    reg [7:0] shift_reg_q;
    reg [2:0] bit_cnt_q;
    reg out_bit_q;
    reg sclk_q;
    reg [7:0] div_q;
    reg [4:0] tick_q;
    reg drive_sdo;

    wire cpha;
    wire selected;
    wire s_lead;
    wire s_trail;
    wire m_tick;
    wire [4:0] tick_n;
    wire m_lead;
    wire m_trail;
    wire m_samp;
    wire m_end;
    wire samp_ev;
    wire out_ev;
    wire byte_done;
    wire in_progress;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire load_buf;
    reg [7:0] half_len;

    assign cpha = ~out_on_idle_edge;

    always @(posedge clk_sys) begin
        if (rst) begin
            sck_sync_q <= {3{clk_idle_high}};
            sdi_sync_q <= 3'h0;
            ss_sync_q <= 3'h7;
            sck_s_q <= clk_idle_high;
            sdi_s_q <= 1'b0;
            ss_n_s_q <= 1'b1;
            sck_prev_q <= clk_idle_high;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], sck_i};
            sdi_sync_q <= {sdi_sync_q[1:0], sdi_i};
            ss_sync_q <= {ss_sync_q[1:0], ss_n_i};
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_s_q <= sck_sync_q[2];
            end
            if (sdi_sync_q[1] == sdi_sync_q[2]) begin
                sdi_s_q <= sdi_sync_q[2];
            end
            if (ss_sync_q[1] == ss_sync_q[2]) begin
                ss_n_s_q <= ss_sync_q[2];
            end
            sck_prev_q <= sck_s_q;
        end
    end

    // Select mode only matters in slave role
    // Slave addressed while select is low
    assign selected = master_en || !slave_select_en || !ss_n_s_q;

    // Slave edges come from the sampled clock pin
    assign s_lead = !master_en && selected && (sck_s_q != sck_prev_q)
        && (sck_s_q != clk_idle_high);
    assign s_trail = !master_en && selected && (sck_s_q != sck_prev_q)
        && (sck_s_q == clk_idle_high);

    // Rate select only used by the master divider
    always @* begin
        case (clk_rate_sel)
            `SSP_RATE_SEL0: half_len = `SSP_HALF_RATE0;
            `SSP_RATE_SEL1: half_len = `SSP_HALF_RATE1;
            `SSP_RATE_SEL2: half_len = `SSP_HALF_RATE2;
            default: half_len = `SSP_HALF_RATE3;
        endcase
    end

    // Half-period ticks from the clk_sys divider
    assign m_tick = master_en && (state_q == ST_RUN) && (div_q == half_len - 8'd1);
    assign tick_n = tick_q + 5'd1;
    assign m_lead = m_tick && tick_n[0] && (tick_n < `SSP_TICK_LAST_TOGGLE);
    assign m_trail = m_tick && !tick_n[0] && (tick_n <= `SSP_TICK_LAST_TOGGLE);
    assign m_samp = sample_late
        ? (cpha ? (m_tick && tick_n[0] && tick_n >= `SSP_TICK_FIRST_LATE) : m_trail)
        : (cpha ? m_trail : m_lead);
    assign m_end = m_tick && (tick_n == ((sample_late && cpha)
        ? `SSP_TICK_LATE_END : `SSP_TICK_LAST_TOGGLE));

    // Sample and output edges from polarity and phase
    assign samp_ev = master_en ? m_samp : (cpha ? s_trail : s_lead);
    assign out_ev = master_en ? (cpha ? m_lead : m_trail) : (cpha ? s_lead : s_trail);

    assign byte_done = samp_ev && (bit_cnt_q == `SSP_LAST_BIT);

    assign in_progress = (state_q != ST_IDLE);

    // Queue between shift register and buffer
    ssp_fifo #(
        .WIDTH(`SSP_BYTE_W),
        .DEPTH(`SSP_FIFO_DEPTH),
        .AW(`SSP_FIFO_AW)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(byte_done),
        .in_ready(fifo_in_ready),
        .in_data({shift_reg_q[6:0], sdi_s_q}),
        .out_valid(fifo_out_valid),
        .out_ready(load_buf),
        .out_data(fifo_out_data)
    );

    assign load_buf = fifo_out_valid && (!buffer_full_flag_q || buf_rd);

    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            shift_reg_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            out_bit_q <= 1'b0;
            sclk_q <= 1'b0;
            div_q <= 8'h00;
            tick_q <= 5'h00;
        end else begin
            // Buffer writes are the only way into the shift register
            // A write while busy is dropped
            if (buf_wr && !in_progress) begin
                shift_reg_q <= buf_wr_data;
                out_bit_q <= buf_wr_data[7];
                bit_cnt_q <= 3'h0;
            end else if (samp_ev) begin
                // Shift in at the bottom, MSb leaves first
                shift_reg_q <= {shift_reg_q[6:0], sdi_s_q};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (out_ev && !(buf_wr && !in_progress)) begin
                out_bit_q <= samp_ev ? shift_reg_q[6] : shift_reg_q[7];
            end
            if (!master_en) begin
                sclk_q <= clk_idle_high;
            end else if (m_tick && tick_n <= `SSP_TICK_LAST_TOGGLE) begin
                sclk_q <= ~sclk_q;
            end else if (state_q == ST_IDLE) begin
                sclk_q <= clk_idle_high;
            end
            if (m_tick) begin
                div_q <= 8'h00;
                tick_q <= tick_n;
            end else if (state_q == ST_RUN && master_en) begin
                div_q <= div_q + 8'h01;
            end
            case (state_q)
                ST_IDLE: begin
                    div_q <= 8'h00;
                    tick_q <= 5'h00;
                    if (buf_wr) begin
                        state_q <= master_en ? ST_PEND : ST_IDLE;
                    end else if (s_lead) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_PEND: begin
                    // Start waits for room so no received byte is lost
                    if (!master_en) begin
                        state_q <= ST_IDLE;
                    end else if (fifo_in_ready) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (master_en ? m_end : byte_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (!master_en && !selected) begin
                bit_cnt_q <= 3'h0;
                state_q <= ST_IDLE;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            xfer_buffer_q <= 8'h00;
            buffer_full_flag_q <= 1'b0;
            port_irq_flag_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            busy_q <= 1'b0;
            rx_overrun_q <= 1'b0;
        end else begin
            // Queued byte moves into the buffer, full set wins
            if (load_buf) begin
                xfer_buffer_q <= fifo_out_data;
                buffer_full_flag_q <= 1'b1;
            end else if (buf_rd) begin
                buffer_full_flag_q <= 1'b0;
            end
            // Interrupt flag on each finished byte
            if (byte_done) begin
                port_irq_flag_q <= 1'b1;
            end else if (irq_clear) begin
                port_irq_flag_q <= 1'b0;
            end
            // Collision flagged on a busy write
            if (buf_wr && in_progress) begin
                write_collision_flag_q <= 1'b1;
            end else if (write_collision_flag_clear) begin
                write_collision_flag_q <= 1'b0;
            end
            // Slave cannot be stalled, so a full queue drops the byte
            if (byte_done && !fifo_in_ready) begin
                rx_overrun_q <= 1'b1;
            end else if (buf_rd) begin
                rx_overrun_q <= 1'b0;
            end
            busy_q <= in_progress;
        end
    end

    always @* begin
        drive_sdo = master_en || selected;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            sck_o_q <= 1'b0;
            sck_oe_q <= 1'b0;
            sdo_o_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else begin
            sck_o_q <= open_drain_select ? 1'b0 : sclk_q;
            sck_oe_q <= master_en && (!open_drain_select || !sclk_q);
            sdo_o_q <= open_drain_select ? 1'b0 : out_bit_q;
            sdo_oe_q <= drive_sdo && (!open_drain_select || !out_bit_q);
        end
    end
endmodule

`default_nettype wire
